/* File: design/mscg_stats_counters.sv */
// four mib statistics counters with threshold flag and register access port
// Notes on behaviour
// (R1) The deferral counter counts a frame whose deferral time runs past the defer limit.
// (R2) The deferral counter counts any one frame at most once however long it defers.
// (R3) The deferral counter rolls over to zero on the increment after it holds 0xFFF.
// (R4) The deferral counter reaching 0xC000 raises the statistics threshold flag.
// (R5) A 32-bit counter counts each frame sent successfully.
// (R6) The sent-ok counter wraps to zero on the increment after all ones.
// (R7) The sent-ok counter reaching 0xC0000000 raises the statistics threshold flag.
// (R8) The sent-ok counter is zero at reset.
// (R9) The oversize counter counts each received frame longer than the maximum frame length.
// (R10) The 16-bit oversize counter wraps to zero on the increment after all ones.
// (R11) The oversize counter reaching 0xC000 raises the statistics threshold flag.
// (R12) The length counter counts a frame whose in-range length field differs from its data count.
// (R13) It also counts a frame whose length field is below the minimum and data count above it.
// (R14) The 16-bit length counter wraps to zero after all ones.
// (R15) The length counter reaching 0xC000 raises the statistics threshold flag.
// (R16) A counter counts only with the global enable set and its own mask bit clear.
// (R17) A disabled counter ignores its events and keeps its value.
`include "mscg_map.svh"

module mscg_stats_counters (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // configuration from the mac control, mask and frame size registers
  input wire logic stats_global_enable,
  input wire logic [3:0] stats_mask_reg,
  input wire logic [15:0] max_frame_length_reg,
  input wire logic [15:0] defer_limit,
  // transmit path events
  input wire logic tx_frame_start,
  input wire logic [15:0] tx_defer_time,
  input wire logic tx_sent_ok,
  // receive path events
  input wire logic rx_frame_done,
  input wire logic [15:0] rx_frame_length,
  input wire logic [15:0] rx_length_type,
  input wire logic [15:0] rx_data_octets,
  // register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // request to set the update bit of the interrupt status register
  output logic stats_threshold_flag
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] bump(input logic [31:0] v, input logic [31:0] top);
    bump = (v == top) ? 32'h00000000 : v + 32'h00000001;
  endfunction

  function automatic logic [15:0] bump16(input logic [15:0] v, input logic [31:0] top);
    logic [31:0] w;
    w = bump({16'h0000, v}, top);
    bump16 = w[15:0];
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  mscg_pkg::mscg_state_s st_ff;
  mscg_pkg::mscg_state_s nxt_st;

  logic en_defer;
  logic en_sent;
  logic en_over;
  logic en_len;
  logic ev_defer;
  logic ev_over;
  logic ev_len;
  logic inc_defer;
  logic inc_sent;
  logic inc_over;
  logic inc_len;
  logic lt_in_range;
  logic lt_short;
  logic wr_defer;
  logic wr_sent;
  logic wr_over;
  logic wr_len;

  assign en_defer = stats_global_enable && !stats_mask_reg[`MSCG_MASK_DEFER]; // R16
  assign en_sent = stats_global_enable && !stats_mask_reg[`MSCG_MASK_SENT_OK]; // R16
  assign en_over = stats_global_enable && !stats_mask_reg[`MSCG_MASK_OVERSIZE]; // R16
  assign en_len = stats_global_enable && !stats_mask_reg[`MSCG_MASK_LEN_ERR]; // R16

  assign lt_in_range = (rx_length_type >= `MSCG_MIN_UNPADDED) &&
                       (rx_length_type <= `MSCG_MAX_CLIENT);
  assign lt_short = rx_length_type < `MSCG_MIN_UNPADDED;

  // a new frame start re-arms the once-per-frame latch
  assign ev_defer = (tx_defer_time > defer_limit) &&
                    !(st_ff.defer_counted && !tx_frame_start); // R1 R2
  assign ev_over = rx_frame_done && (rx_frame_length > max_frame_length_reg); // R9
  assign ev_len = rx_frame_done &&
                  ((lt_in_range && (rx_length_type != rx_data_octets)) || // R12
                   (lt_short && (rx_data_octets > `MSCG_MIN_UNPADDED))); // R13

  // a counter written in the same cycle drops its event, so no flag follows a lost count
  assign wr_defer = reg_wr && (reg_addr == `MSCG_OFS_DEFER);
  assign wr_sent = reg_wr && (reg_addr == `MSCG_OFS_SENT_OK);
  assign wr_over = reg_wr && (reg_addr == `MSCG_OFS_OVERSIZE);
  assign wr_len = reg_wr && (reg_addr == `MSCG_OFS_LEN_ERR);

  assign inc_defer = ev_defer && en_defer && !wr_defer; // R17
  assign inc_sent = tx_sent_ok && en_sent && !wr_sent; // R17
  assign inc_over = ev_over && en_over && !wr_over; // R17
  assign inc_len = ev_len && en_len && !wr_len; // R17

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.threshold_flag = 1'b0;
    if (tx_frame_start) begin
      nxt_st.defer_counted = 1'b0;
    end
    if (inc_defer) begin
      nxt_st.defer_cnt = bump16(st_ff.defer_cnt, `MSCG_TOP_DEFER); // R3
      nxt_st.defer_counted = 1'b1; // R2
    end
    if (inc_sent) begin
      nxt_st.sent_ok_cnt = bump(st_ff.sent_ok_cnt, `MSCG_TOP_SENT_OK); // R5 R6
    end
    if (inc_over) begin
      nxt_st.oversize_cnt = bump16(st_ff.oversize_cnt, `MSCG_TOP_CNT16); // R10
    end
    if (inc_len) begin
      nxt_st.len_err_cnt = bump16(st_ff.len_err_cnt, `MSCG_TOP_CNT16); // R14
    end
    if ((inc_defer && nxt_st.defer_cnt == `MSCG_THR_CNT16) || // R4
        (inc_sent && nxt_st.sent_ok_cnt == `MSCG_THR_SENT_OK) || // R7
        (inc_over && nxt_st.oversize_cnt == `MSCG_THR_CNT16) || // R11
        (inc_len && nxt_st.len_err_cnt == `MSCG_THR_CNT16)) begin // R15
      nxt_st.threshold_flag = 1'b1;
    end
    // software write overrides a same-cycle increment
    if (reg_wr) begin
      case (reg_addr)
        `MSCG_OFS_SENT_OK: nxt_st.sent_ok_cnt = reg_wdata;
        `MSCG_OFS_DEFER: nxt_st.defer_cnt = reg_wdata[15:0];
        `MSCG_OFS_OVERSIZE: nxt_st.oversize_cnt = reg_wdata[15:0];
        `MSCG_OFS_LEN_ERR: nxt_st.len_err_cnt = reg_wdata[15:0];
        default: nxt_st.rdata = st_ff.rdata;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `MSCG_OFS_SENT_OK: nxt_st.rdata = st_ff.sent_ok_cnt;
        `MSCG_OFS_DEFER: nxt_st.rdata = {16'h0000, st_ff.defer_cnt};
        `MSCG_OFS_OVERSIZE: nxt_st.rdata = {16'h0000, st_ff.oversize_cnt};
        `MSCG_OFS_LEN_ERR: nxt_st.rdata = {16'h0000, st_ff.len_err_cnt};
        default: nxt_st.rdata = 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff.defer_cnt <= `MSCG_RST_CNT16;
      st_ff.sent_ok_cnt <= `MSCG_RST_SENT_OK; // R8
      st_ff.oversize_cnt <= `MSCG_RST_CNT16;
      st_ff.len_err_cnt <= `MSCG_RST_CNT16;
      st_ff.defer_counted <= 1'b0;
      st_ff.threshold_flag <= 1'b0;
      st_ff.rdata <= 32'h00000000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign stats_threshold_flag = st_ff.threshold_flag;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_defer_count;
    @(posedge sys_clk) disable iff (!rst_n)
      (ev_defer && en_defer && !reg_wr && st_ff.defer_cnt != 16'h0FFF)
      |=> st_ff.defer_cnt == $past(st_ff.defer_cnt) + 16'h0001;
  endproperty
  a_defer_count: assert property (p_defer_count) else $error("deferral not counted"); // R1

  property p_defer_once;
    @(posedge sys_clk) disable iff (!rst_n)
      (inc_defer && !reg_wr) ##1 (!tx_frame_start && !reg_wr)
      |=> st_ff.defer_cnt == $past(st_ff.defer_cnt, 1);
  endproperty
  a_defer_once: assert property (p_defer_once) else $error("deferral counted twice"); // R2

  property p_defer_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
      (inc_defer && !reg_wr && st_ff.defer_cnt == 16'h0FFF) |=> st_ff.defer_cnt == 16'h0000;
  endproperty
  a_defer_wrap: assert property (p_defer_wrap) else $error("deferral wrap wrong"); // R3

  property p_sent_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
      (inc_sent && !reg_wr && st_ff.sent_ok_cnt == 32'hFFFFFFFF) |=> st_ff.sent_ok_cnt == 0;
  endproperty
  a_sent_wrap: assert property (p_sent_wrap) else $error("sent-ok wrap wrong"); // R6

  property p_sent_thr;
    @(posedge sys_clk) disable iff (!rst_n)
      (inc_sent && !reg_wr && st_ff.sent_ok_cnt == 32'hBFFFFFFF) |=> stats_threshold_flag;
  endproperty
  a_sent_thr: assert property (p_sent_thr) else $error("sent-ok threshold missed"); // R7

  property p_over_count;
    @(posedge sys_clk) disable iff (!rst_n)
      (rx_frame_done && rx_frame_length > max_frame_length_reg && en_over && !reg_wr)
      |=> st_ff.oversize_cnt == $past(st_ff.oversize_cnt) + 16'h0001;
  endproperty
  a_over_count: assert property (p_over_count) else $error("oversize not counted"); // R9

  property p_over_thr;
    @(posedge sys_clk) disable iff (!rst_n)
      (inc_over && !reg_wr && st_ff.oversize_cnt == 16'hBFFF) |=> stats_threshold_flag;
  endproperty
  a_over_thr: assert property (p_over_thr) else $error("oversize threshold missed"); // R11

  property p_len_short;
    @(posedge sys_clk) disable iff (!rst_n)
      (rx_frame_done && lt_short && rx_data_octets > 16'h002E && en_len && !reg_wr)
      |=> st_ff.len_err_cnt == $past(st_ff.len_err_cnt) + 16'h0001;
  endproperty
  a_len_short: assert property (p_len_short) else $error("short length error missed"); // R13

  property p_len_thr;
    @(posedge sys_clk) disable iff (!rst_n)
      (inc_len && !reg_wr && st_ff.len_err_cnt == 16'hBFFF) |=> stats_threshold_flag;
  endproperty
  a_len_thr: assert property (p_len_thr) else $error("length threshold missed"); // R15

  property p_disabled_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (!stats_global_enable && !reg_wr) |=> $stable(st_ff.sent_ok_cnt) &&
      $stable(st_ff.oversize_cnt) && $stable(st_ff.len_err_cnt) && $stable(st_ff.defer_cnt);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) else $error("disabled counter moved"); // R16

  property p_masked_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (stats_mask_reg[`MSCG_MASK_SENT_OK] && !reg_wr) |=> $stable(st_ff.sent_ok_cnt);
  endproperty
  a_masked_hold: assert property (p_masked_hold) else $error("masked counter moved"); // R17

  property p_flag_pulse;
    @(posedge sys_clk) disable iff (!rst_n)
      stats_threshold_flag |=> !stats_threshold_flag ||
      $past(inc_defer || inc_sent || inc_over || inc_len);
  endproperty
  a_flag_pulse: assert property (p_flag_pulse) else $error("flag held without cause");

  property p_reset_zero;
    @(posedge sys_clk)
      !rst_n |=> st_ff.sent_ok_cnt == 32'h00000000 && st_ff.defer_cnt == 16'h0000 &&
      st_ff.oversize_cnt == 16'h0000 && st_ff.len_err_cnt == 16'h0000 &&
      !stats_threshold_flag && reg_rdata == 32'h00000000;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("counters not cleared by reset"); // R8

  property p_sent_count;
    @(posedge sys_clk) disable iff (!rst_n)
      (inc_sent && !reg_wr && st_ff.sent_ok_cnt != 32'hFFFFFFFF)
      |=> st_ff.sent_ok_cnt == $past(st_ff.sent_ok_cnt) + 32'h00000001;
  endproperty
  a_sent_count: assert property (p_sent_count) else $error("sent-ok not counted"); // R5

  property p_defer_thr;
    @(posedge sys_clk) disable iff (!rst_n)
      (inc_defer && !reg_wr && st_ff.defer_cnt == 16'hBFFF) |=> stats_threshold_flag;
  endproperty
  a_defer_thr: assert property (p_defer_thr) else $error("deferral threshold missed"); // R4

  property p_over_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
      (inc_over && !reg_wr && st_ff.oversize_cnt == 16'hFFFF) |=> st_ff.oversize_cnt == 16'h0000;
  endproperty
  a_over_wrap: assert property (p_over_wrap) else $error("oversize wrap wrong"); // R10

  property p_over_short;
    @(posedge sys_clk) disable iff (!rst_n)
      (rx_frame_done && rx_frame_length <= max_frame_length_reg && !reg_wr)
      |=> $stable(st_ff.oversize_cnt);
  endproperty
  a_over_short: assert property (p_over_short) else $error("frame in size counted"); // R9

  property p_len_range;
    @(posedge sys_clk) disable iff (!rst_n)
      (rx_frame_done && lt_in_range && rx_length_type != rx_data_octets && en_len &&
       !reg_wr)
      |=> st_ff.len_err_cnt == $past(st_ff.len_err_cnt) + 16'h0001;
  endproperty
  a_len_range: assert property (p_len_range) else $error("in-range length error missed"); // R12

  property p_len_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
      (inc_len && !reg_wr && st_ff.len_err_cnt == 16'hFFFF) |=> st_ff.len_err_cnt == 16'h0000;
  endproperty
  a_len_wrap: assert property (p_len_wrap) else $error("length wrap wrong"); // R14

  property p_defer_masked;
    @(posedge sys_clk) disable iff (!rst_n)
      (stats_mask_reg[`MSCG_MASK_DEFER] && !reg_wr) |=> $stable(st_ff.defer_cnt);
  endproperty
  a_defer_masked: assert property (p_defer_masked) else $error("masked deferral moved"); // R17

  property p_wr_wins;
    @(posedge sys_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == `MSCG_OFS_SENT_OK) |=> st_ff.sent_ok_cnt == $past(reg_wdata);
  endproperty
  a_wr_wins: assert property (p_wr_wins) else $error("sent-ok write lost");

  property p_rd_unmapped;
    @(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && reg_addr != `MSCG_OFS_SENT_OK && reg_addr != `MSCG_OFS_DEFER &&
       reg_addr != `MSCG_OFS_OVERSIZE && reg_addr != `MSCG_OFS_LEN_ERR)
      |=> reg_rdata == 32'h00000000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  property p_flag_cause;
    @(posedge sys_clk) disable iff (!rst_n)
      stats_threshold_flag |-> st_ff.sent_ok_cnt == 32'hC0000000 ||
      st_ff.defer_cnt == 16'hC000 || st_ff.oversize_cnt == 16'hC000 ||
      st_ff.len_err_cnt == 16'hC000;
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag without threshold"); // R4 R7 R11 R15

  c_defer: cover property (@(posedge sys_clk) disable iff (!rst_n) inc_defer);
  c_sent: cover property (@(posedge sys_clk) disable iff (!rst_n) inc_sent);
  c_over: cover property (@(posedge sys_clk) disable iff (!rst_n) inc_over);
  c_len: cover property (@(posedge sys_clk) disable iff (!rst_n) inc_len);
  c_flag: cover property (@(posedge sys_clk) disable iff (!rst_n) stats_threshold_flag);

endmodule // mscg_stats_counters

/* File: design/mscg_map.svh */
// offsets, field positions, reset values and limits of the statistics counter group
`ifndef MSCG_MAP_SVH
`define MSCG_MAP_SVH
`define MSCG_OFS_SENT_OK 8'hDC
`define MSCG_OFS_DEFER 8'hD8
`define MSCG_OFS_OVERSIZE 8'hE0
`define MSCG_OFS_LEN_ERR 8'hE2
`define MSCG_MASK_DEFER 0
`define MSCG_MASK_SENT_OK 1
`define MSCG_MASK_OVERSIZE 2
`define MSCG_MASK_LEN_ERR 3
`define MSCG_RST_SENT_OK 32'h00000000
`define MSCG_RST_CNT16 16'h0000
`define MSCG_TOP_DEFER 32'h00000FFF
`define MSCG_TOP_CNT16 32'h0000FFFF
`define MSCG_TOP_SENT_OK 32'hFFFFFFFF
`define MSCG_THR_CNT16 16'hC000
`define MSCG_THR_SENT_OK 32'hC0000000
`define MSCG_MIN_UNPADDED 16'h002E
`define MSCG_MAX_CLIENT 16'h05DC
`endif

/* File: design/mscg_pkg.sv */
// types of the statistics counter group
package mscg_pkg;
  typedef struct packed {
    logic [15:0] defer_cnt;
    logic [31:0] sent_ok_cnt;
    logic [15:0] oversize_cnt;
    logic [15:0] len_err_cnt;
    logic defer_counted;
    logic threshold_flag;
    logic [31:0] rdata;
  } mscg_state_s;
endpackage

/* File: tb/test_mscg_stats_counters.sv */
// self-checking bench for the statistics counter group
`include "mscg_map.svh"
module test_mscg_stats_counters;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, stats_global_enable, tx_frame_start, tx_sent_ok, rx_frame_done;
  logic reg_wr, reg_rd, stats_threshold_flag;
  logic [3:0] stats_mask_reg;
  logic [7:0] reg_addr;
  logic [15:0] max_frame_length_reg, defer_limit, tx_defer_time;
  logic [15:0] rx_frame_length, rx_length_type, rx_data_octets;
  logic [31:0] reg_wdata, reg_rdata;
  int mismatches = 0;
  int compares = 0;
  mscg_stats_counters u_mscg_stats_counters (.sys_clk(sys_clk), .rst_n(rst_n),
    .stats_global_enable(stats_global_enable), .stats_mask_reg(stats_mask_reg),
    .max_frame_length_reg(max_frame_length_reg), .defer_limit(defer_limit),
    .tx_frame_start(tx_frame_start), .tx_defer_time(tx_defer_time), .tx_sent_ok(tx_sent_ok),
    .rx_frame_done(rx_frame_done), .rx_frame_length(rx_frame_length),
    .rx_length_type(rx_length_type), .rx_data_octets(rx_data_octets), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .stats_threshold_flag(stats_threshold_flag));
  // ------------------------------------------------------------
  // clock, reset and tasks
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic print_verdict();
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge sys_clk);
    reg_rd = 1'b1; reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask
  // one-cycle event pulses, flag looked at in the following cycle
  task automatic pulse(input logic s, input logic r, input logic f, input logic expf);
    @(negedge sys_clk);
    tx_sent_ok = s; rx_frame_done = r; tx_frame_start = f;
    @(negedge sys_clk);
    tx_sent_ok = 1'b0; rx_frame_done = 1'b0; tx_frame_start = 1'b0;
    chk({31'h0, stats_threshold_flag}, {31'h0, expf});
  endtask
  // new frame that stays over the defer limit for several cycles
  task automatic defer_frame(input logic expf);
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    tx_defer_time = 16'h0020;
    @(negedge sys_clk);
    chk({31'h0, stats_threshold_flag}, {31'h0, expf});
    repeat (5) @(negedge sys_clk);
    tx_defer_time = 16'h0005;
  endtask
  task automatic rx_frame(input logic [15:0] len, input logic [15:0] lt, input logic [15:0] n,
                          input logic expf);
    rx_frame_length = len; rx_length_type = lt; rx_data_octets = n;
    pulse(1'b0, 1'b1, 1'b0, expf);
  endtask
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n, stats_global_enable, tx_frame_start, tx_sent_ok, rx_frame_done} = 5'h00;
    {reg_wr, reg_rd, reg_addr, reg_wdata, stats_mask_reg} = '0;
    max_frame_length_reg = 16'h05EE; defer_limit = 16'h0010; tx_defer_time = 16'h0005;
    rx_frame_length = 16'h0040; rx_length_type = 16'h0064; rx_data_octets = 16'h0064;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    rd(`MSCG_OFS_SENT_OK, 32'h00000000);
    rd(8'h00, 32'h00000000);
    // a write to an unmapped offset leaves the counters alone
    wr(8'hDE, 32'h0000ABCD);
    rd(`MSCG_OFS_SENT_OK, 32'h00000000);
    stats_global_enable = 1'b1;
    repeat (3) pulse(1'b1, 1'b0, 1'b0, 1'b0);
    rd(`MSCG_OFS_SENT_OK, 32'h00000003);
    wr(`MSCG_OFS_SENT_OK, 32'hBFFFFFFF);
    pulse(1'b1, 1'b0, 1'b0, 1'b1);
    rd(`MSCG_OFS_SENT_OK, 32'hC0000000);
    wr(`MSCG_OFS_SENT_OK, 32'hFFFFFFFF);
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    rd(`MSCG_OFS_SENT_OK, 32'h00000000);
    defer_frame(1'b0);
    defer_frame(1'b0);
    rd(`MSCG_OFS_DEFER, 32'h00000002);
    wr(`MSCG_OFS_DEFER, 32'h00000FFF);
    defer_frame(1'b0);
    rd(`MSCG_OFS_DEFER, 32'h00000000);
    wr(`MSCG_OFS_DEFER, 32'h0000BFFF);
    defer_frame(1'b1);
    rd(`MSCG_OFS_DEFER, 32'h0000C000);
    rx_frame(16'h05EE, 16'h0064, 16'h0064, 1'b0);
    rx_frame(16'h05EF, 16'h0064, 16'h0064, 1'b0);
    rd(`MSCG_OFS_OVERSIZE, 32'h00000001);
    wr(`MSCG_OFS_OVERSIZE, 32'h0000BFFF);
    rx_frame(16'h0600, 16'h0064, 16'h0064, 1'b1);
    wr(`MSCG_OFS_OVERSIZE, 32'h0000FFFF);
    rx_frame(16'h0600, 16'h0064, 16'h0064, 1'b0);
    rd(`MSCG_OFS_OVERSIZE, 32'h00000000);
    wr(`MSCG_OFS_LEN_ERR, 32'h0000BFFF);
    rx_frame(16'h0040, 16'h0064, 16'h005A, 1'b1);
    rx_frame(16'h0040, 16'h0028, 16'h0032, 1'b0);
    rx_frame(16'h0040, 16'h0028, 16'h002E, 1'b0);
    rx_frame(16'h0040, 16'h002E, 16'h0030, 1'b0);
    rx_frame(16'h0040, 16'h05DC, 16'h05DB, 1'b0);
    rd(`MSCG_OFS_LEN_ERR, 32'h0000C003);
    wr(`MSCG_OFS_LEN_ERR, 32'h0000FFFF);
    rx_frame(16'h0040, 16'h0064, 16'h005A, 1'b0);
    rd(`MSCG_OFS_LEN_ERR, 32'h00000000);
    // all counters at five, then events under each kind of disable
    wr(`MSCG_OFS_SENT_OK, 32'h5); wr(`MSCG_OFS_DEFER, 32'h5);
    wr(`MSCG_OFS_OVERSIZE, 32'h5); wr(`MSCG_OFS_LEN_ERR, 32'h5);
    for (int i = 0; i < 3; i++) begin
      stats_mask_reg = (i == 0) ? 4'hF : ((i == 1) ? 4'h0 : 4'hE);
      stats_global_enable = (i != 1);
      defer_frame(1'b0);
      pulse(1'b1, 1'b0, 1'b0, 1'b0);
      rx_frame(16'h0600, 16'h0064, 16'h005A, 1'b0);
      rd(`MSCG_OFS_DEFER, (i == 2) ? 32'h6 : 32'h5);
      rd(`MSCG_OFS_SENT_OK, 32'h5);
      rd(`MSCG_OFS_OVERSIZE, 32'h5);
      rd(`MSCG_OFS_LEN_ERR, 32'h5);
    end
    // mid-run reset clears counters that hold nonzero values
    @(negedge sys_clk);
    rst_n = 1'b0;
    @(negedge sys_clk);
    rst_n = 1'b1;
    rd(`MSCG_OFS_SENT_OK, 32'h00000000);
    rd(`MSCG_OFS_DEFER, 32'h00000000);
    print_verdict();
  end
endmodule // test_mscg_stats_counters
